// >>> hw/scr_pkg.sv
// package: register map, field layout, reset values and bus types for the synth calibration registers
package scr_pkg;

    // ------------------------------------------------------------
    // register byte addresses (offsets are not word multiples, so index * 4)
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_PUMP = 16'hDF1C;
    localparam logic [15:0] IDX_OSC = 16'hDF1D;
    localparam logic [15:0] IDX_COARSE = 16'hDF1E;
    localparam logic [15:0] IDX_CONTROL = 16'hDF1F;
    localparam logic [15:0] IDX_SENS = 16'hDF23;
    localparam logic [15:0] IDX_STATUS = 16'hDF30;
    localparam int ADDR_W = 18;
    localparam logic [17:0] ADR_PUMP = {IDX_PUMP, 2'h0};
    localparam logic [17:0] ADR_OSC = {IDX_OSC, 2'h0};
    localparam logic [17:0] ADR_COARSE = {IDX_COARSE, 2'h0};
    localparam logic [17:0] ADR_CONTROL = {IDX_CONTROL, 2'h0};
    localparam logic [17:0] ADR_SENS = {IDX_SENS, 2'h0};
    localparam logic [17:0] ADR_STATUS = {IDX_STATUS, 2'h0};

    // ------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PUMP = 8'hA9;
    localparam logic [7:0] RST_OSC = 8'h0A;
    localparam logic [7:0] RST_COARSE = 8'h20;
    localparam logic [7:0] RST_CONTROL = 8'h0D;
    localparam logic [7:0] RST_SENS = 8'h88;
    localparam logic [7:0] MSK_PUMP = 8'hFF;
    localparam logic [7:0] MSK_OSC = 8'h3F;
    localparam logic [7:0] MSK_COARSE = 8'h3F;
    localparam logic [7:0] MSK_CONTROL = 8'h7F;
    localparam logic [7:0] MSK_SENS = 8'hFF;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_PUMP_CODE = 0;
    localparam int POS_PUMP_CAL_EN = 4;
    localparam int POS_PUMP_CFG = 6;
    localparam int POS_OSC_CORE_HIGH = 5;
    localparam int POS_STAT_PUMP_SKIP = 0;
    localparam int POS_STAT_DEEP_A = 1;
    localparam int POS_STAT_DEEP_B = 2;

    typedef enum logic [2:0] {
        SCR_IDLE = 3'h1,
        SCR_ANSWER = 3'h2,
        SCR_DONE = 3'h4
    } scr_bus_state_t;

    typedef struct packed {
        logic [17:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } scr_av_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
        logic readdatavalid_unused;
    } scr_av_rsp_t;

    typedef struct packed {
        logic [1:0] pump_cfg;
        logic [1:0] pump_current_cal_enable;
        logic [3:0] pump_code;
        logic oscillator_core_high_select;
        logic [4:0] osc_current;
        logic [5:0] coarse_code;
        logic [6:0] cal_control;
        logic [7:0] sens_test;
        logic pump_cal_skip;
    } scr_synth_cfg_t;

endpackage : scr_pkg

// >>> hw/scr_field_reg.sv
// one software-writable register with masked bits and a restore-to-reset input
module scr_field_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hFF
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic restore,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] value
);

    typedef struct packed {
        logic [7:0] val;
    } scr_fr_state_t;

    scr_fr_state_t state_ff;
    scr_fr_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (restore) begin
            nxt_state.val = RESET_VAL;
        end else if (wr_en) begin
            // unused positions stay zero whatever is written
            nxt_state.val = wr_data & WR_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff <= '{val: RESET_VAL};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign value = state_ff.val;

endmodule : scr_field_reg

// >>> hw/scr_wake_detect.sv
// detects the return to active operation from either deepest low-power mode
module scr_wake_detect (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic deep_sleep_mode_a,
    input wire logic deep_sleep_mode_b,
    output logic wake_pulse
);

    typedef struct packed {
        logic was_deep;
        logic pulse;
    } scr_wd_state_t;

    scr_wd_state_t state_ff;
    scr_wd_state_t nxt_state;

    always_comb begin
        nxt_state.was_deep = deep_sleep_mode_a | deep_sleep_mode_b;
        // falling edge of the combined sleep level marks the resume
        nxt_state.pulse = state_ff.was_deep & ~(deep_sleep_mode_a | deep_sleep_mode_b);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff <= '{was_deep: 1'b0, pulse: 1'b0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign wake_pulse = state_ff.pulse;

endmodule : scr_wake_detect

// >>> hw/scr_synth_cal_regs.sv
// synth calibration register bank behind an avalon-mm slave
//
// The Avalon-MM slave port is this design's own decision.

module scr_synth_cal_regs (
    input wire logic clk,
    input wire logic rst_b,
    input wire scr_pkg::scr_av_req_t av_req,
    output scr_pkg::scr_av_rsp_t av_rsp,
    input wire logic deep_sleep_mode_a,
    input wire logic deep_sleep_mode_b,
    output scr_pkg::scr_synth_cfg_t synth_cfg
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        scr_pkg::scr_bus_state_t bus;
        logic waitrequest;
        logic [31:0] readdata;
        scr_pkg::scr_synth_cfg_t cfg;
    } scr_top_state_t;

    scr_top_state_t state_ff;
    scr_top_state_t nxt_state;

    logic wake_pulse;
    logic [7:0] pump_val;
    logic [7:0] osc_val;
    logic [7:0] coarse_val;
    logic [7:0] control_val;
    logic [7:0] sens_val;
    logic wr_fire;
    logic [7:0] wdata;

    // ------------------------------------------------------------
    // write strobe: taken only in the answer cycle, so exactly once
    // ------------------------------------------------------------
    assign wr_fire = av_req.write && !av_req.read && (state_ff.bus == scr_pkg::SCR_ANSWER)
        && av_req.byteenable[0];
    assign wdata = av_req.writedata[7:0];

    scr_wake_detect u_wake (
        .clk(clk),
        .rst_b(rst_b),
        .deep_sleep_mode_a(deep_sleep_mode_a),
        .deep_sleep_mode_b(deep_sleep_mode_b),
        .wake_pulse(wake_pulse)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // result registers restore on wake; a software write loads saved hop values
    scr_field_reg #(.RESET_VAL(scr_pkg::RST_PUMP), .WR_MASK(scr_pkg::MSK_PUMP)) u_pump (
        .clk(clk),
        .rst_b(rst_b),
        .restore(wake_pulse),
        .wr_en(wr_fire && av_req.address == scr_pkg::ADR_PUMP),
        .wr_data(wdata),
        .value(pump_val)
    );

    scr_field_reg #(.RESET_VAL(scr_pkg::RST_OSC), .WR_MASK(scr_pkg::MSK_OSC)) u_osc (
        .clk(clk),
        .rst_b(rst_b),
        .restore(wake_pulse),
        .wr_en(wr_fire && av_req.address == scr_pkg::ADR_OSC),
        .wr_data(wdata),
        .value(osc_val)
    );

    scr_field_reg #(.RESET_VAL(scr_pkg::RST_COARSE), .WR_MASK(scr_pkg::MSK_COARSE)) u_coarse (
        .clk(clk),
        .rst_b(rst_b),
        .restore(wake_pulse),
        .wr_en(wr_fire && av_req.address == scr_pkg::ADR_COARSE),
        .wr_data(wdata),
        .value(coarse_val)
    );

    // control and test settings keep their value through sleep
    scr_field_reg #(.RESET_VAL(scr_pkg::RST_CONTROL), .WR_MASK(scr_pkg::MSK_CONTROL)) u_control (
        .clk(clk),
        .rst_b(rst_b),
        .restore(1'b0),
        .wr_en(wr_fire && av_req.address == scr_pkg::ADR_CONTROL),
        .wr_data(wdata),
        .value(control_val)
    );

    scr_field_reg #(.RESET_VAL(scr_pkg::RST_SENS), .WR_MASK(scr_pkg::MSK_SENS)) u_sens (
        .clk(clk),
        .rst_b(rst_b),
        .restore(1'b0),
        .wr_en(wr_fire && av_req.address == scr_pkg::ADR_SENS),
        .wr_data(wdata),
        .value(sens_val)
    );

    // ------------------------------------------------------------
    // bus answer and outputs
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        // fields to the synthesizer; registered so outputs come from flops
        nxt_state.cfg.pump_cfg = pump_val[scr_pkg::POS_PUMP_CFG +: 2];
        nxt_state.cfg.pump_current_cal_enable = pump_val[scr_pkg::POS_PUMP_CAL_EN +: 2];
        nxt_state.cfg.pump_code = pump_val[scr_pkg::POS_PUMP_CODE +: 4];
        nxt_state.cfg.oscillator_core_high_select = osc_val[scr_pkg::POS_OSC_CORE_HIGH];
        nxt_state.cfg.osc_current = osc_val[4:0];
        nxt_state.cfg.coarse_code = coarse_val[5:0];
        nxt_state.cfg.cal_control = control_val[6:0];
        nxt_state.cfg.sens_test = sens_val;
        nxt_state.cfg.pump_cal_skip = (pump_val[scr_pkg::POS_PUMP_CAL_EN +: 2] == 2'h0);
        case (state_ff.bus)
            scr_pkg::SCR_IDLE: begin
                nxt_state.waitrequest = 1'b1;
                if (av_req.read ^ av_req.write) begin
                    nxt_state.bus = scr_pkg::SCR_ANSWER;
                    nxt_state.waitrequest = 1'b0;
                    // unmapped reads and reserved bits answer zero
                    case (av_req.address)
                        scr_pkg::ADR_PUMP: nxt_state.readdata = {24'h000000, pump_val};
                        scr_pkg::ADR_OSC: nxt_state.readdata = {24'h000000, osc_val};
                        scr_pkg::ADR_COARSE: nxt_state.readdata = {24'h000000, coarse_val};
                        scr_pkg::ADR_CONTROL: nxt_state.readdata = {24'h000000, control_val};
                        scr_pkg::ADR_SENS: nxt_state.readdata = {24'h000000, sens_val};
                        scr_pkg::ADR_STATUS: nxt_state.readdata = {29'h00000000,
                            deep_sleep_mode_b, deep_sleep_mode_a, state_ff.cfg.pump_cal_skip};
                        default: nxt_state.readdata = 32'h00000000;
                    endcase
                end
            end
            scr_pkg::SCR_ANSWER: begin
                // the answer edge; drop waitrequest for one cycle only
                nxt_state.bus = scr_pkg::SCR_DONE;
                nxt_state.waitrequest = 1'b1;
            end
            scr_pkg::SCR_DONE: begin
                // one idle cycle lets the master release before a new decode
                nxt_state.bus = scr_pkg::SCR_IDLE;
                nxt_state.waitrequest = 1'b1;
            end
            default: begin
                nxt_state.bus = scr_pkg::SCR_IDLE;
                nxt_state.waitrequest = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff.bus <= scr_pkg::SCR_IDLE;
            state_ff.waitrequest <= 1'b1;
            state_ff.readdata <= 32'h00000000;
            state_ff.cfg <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign av_rsp.readdata = state_ff.readdata;
    assign av_rsp.waitrequest = state_ff.waitrequest;
    assign av_rsp.readdatavalid_unused = 1'b0;
    assign synth_cfg = state_ff.cfg;

endmodule : scr_synth_cal_regs

// >>> sim/scr_synth_cal_regs_sva.sv
// checker: bus timing, reset values, write and wake behaviour of the synth cal registers
module scr_synth_cal_regs_sva (
    input wire logic clk,
    input wire logic rst_b,
    input wire scr_pkg::scr_av_req_t av_req,
    input wire scr_pkg::scr_av_rsp_t av_rsp,
    input wire logic deep_sleep_mode_a,
    input wire logic deep_sleep_mode_b,
    input wire scr_pkg::scr_synth_cfg_t synth_cfg
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic wr_ok;
    // byteenable[0] low stores nothing, so only writes with byteenable[0] high are tracked
    assign wr_ok = av_req.write && !av_rsp.waitrequest && av_req.byteenable[0];
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_wait_one: assert property ($fell(av_rsp.waitrequest) |=> av_rsp.waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_answer_soon: assert property ($rose(av_req.read || av_req.write) |-> ##[1:3] !av_rsp.waitrequest)
        else $error("access not answered in time");
    a_upper_zero: assert property (!av_rsp.waitrequest |-> av_rsp.readdata[31:8] == 24'h0)
        else $error("readdata upper bits not zero");
    a_reset_vals: assert property ($rose(rst_b) |-> ##3 ({synth_cfg.pump_cfg, synth_cfg.pump_current_cal_enable,
        synth_cfg.pump_code} == 8'hA9 && !synth_cfg.oscillator_core_high_select && synth_cfg.osc_current == 5'h0A
        && synth_cfg.coarse_code == 6'h20 && synth_cfg.cal_control == 7'h0D
        && synth_cfg.sens_test == 8'h88))
        else $error("config not at reset values");
    a_skip_flag: assert property ($past(rst_b, 3) |-> synth_cfg.pump_cal_skip
        == (synth_cfg.pump_current_cal_enable == 2'h0))
        else $error("pump skip flag wrong");
    a_pump_write: assert property (wr_ok && av_req.address == scr_pkg::ADR_PUMP |-> ##2 {synth_cfg.pump_cfg,
        synth_cfg.pump_current_cal_enable, synth_cfg.pump_code} == $past(av_req.writedata[7:0], 2))
        else $error("pump write not applied");
    a_osc_write: assert property (wr_ok && av_req.address == scr_pkg::ADR_OSC |-> ##2
        {synth_cfg.oscillator_core_high_select, synth_cfg.osc_current} == $past(av_req.writedata[5:0], 2))
        else $error("osc write not applied");
    a_coarse_write: assert property (wr_ok && av_req.address == scr_pkg::ADR_COARSE |-> ##2
        synth_cfg.coarse_code == $past(av_req.writedata[5:0], 2))
        else $error("coarse write not applied");
    a_ctrl_write: assert property (wr_ok && av_req.address == scr_pkg::ADR_CONTROL |-> ##2
        synth_cfg.cal_control == $past(av_req.writedata[6:0], 2))
        else $error("control write not applied");
    a_wake_restore: assert property ($fell(deep_sleep_mode_a || deep_sleep_mode_b) |-> ##3 (synth_cfg.pump_code == 4'h9
        && synth_cfg.osc_current == 5'h0A && synth_cfg.coarse_code == 6'h20))
        else $error("results not restored on wake");
    c_pump_write: cover property (wr_ok && av_req.address == scr_pkg::ADR_PUMP);
    c_read_done: cover property (av_req.read && !av_rsp.waitrequest);
    c_wake: cover property ($fell(deep_sleep_mode_a || deep_sleep_mode_b));
endmodule : scr_synth_cal_regs_sva
bind scr_synth_cal_regs scr_synth_cal_regs_sva u_sva (.clk(clk), .rst_b(rst_b), .av_req(av_req), .av_rsp(av_rsp),
    .deep_sleep_mode_a(deep_sleep_mode_a), .deep_sleep_mode_b(deep_sleep_mode_b), .synth_cfg(synth_cfg));

// >>> sim/scr_synth_cal_regs_tb.sv
// testbench: register map, masks, hop reload and wake restore of the synth cal registers
module scr_synth_cal_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic rst_b;
    scr_pkg::scr_av_req_t av_req;
    scr_pkg::scr_av_rsp_t av_rsp;
    logic deep_sleep_mode_a;
    logic deep_sleep_mode_b;
    scr_pkg::scr_synth_cfg_t synth_cfg;
    int fails;
    int n_tests;
    logic [17:0] adrs [5] = '{18'h37C70, 18'h37C74, 18'h37C78, 18'h37C7C, 18'h37C8C};
    logic [7:0] rsts [5] = '{8'hA9, 8'h0A, 8'h20, 8'h0D, 8'h88};
    logic [7:0] msks [5] = '{8'hFF, 8'h3F, 8'h3F, 8'h7F, 8'hFF};
    scr_synth_cal_regs uut (.clk(clk), .rst_b(rst_b), .av_req(av_req), .av_rsp(av_rsp),
        .deep_sleep_mode_a(deep_sleep_mode_a), .deep_sleep_mode_b(deep_sleep_mode_b), .synth_cfg(synth_cfg));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // holds the request until waitrequest is sampled low, then releases for one idle cycle
    task automatic bus(input logic wr, input logic [17:0] adr, input logic [7:0] wd, output logic [31:0] q);
        int n;
        n = 0;
        av_req.address <= adr;
        av_req.write <= wr;
        av_req.read <= !wr;
        av_req.writedata <= {24'h0, wd};
        do begin
            @(posedge clk);
            n++;
        end while (av_rsp.waitrequest !== 1'b0 && n < 20);
        if (av_rsp.waitrequest !== 1'b0) begin
            fails++;
            $display("wrong value at %0t: bus timeout", $time);
            print_verdict();
        end
        q = av_rsp.readdata;
        av_req.read <= 1'b0;
        av_req.write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [17:0] adr, input logic [7:0] wd);
        logic [31:0] q;
        bus(1'b1, adr, wd, q);
    endtask : wr
    task automatic rdc(input logic [17:0] adr, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, adr, 8'h00, q);
        chk(q, {24'h0, exp}, "readback");
    endtask : rdc
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 5; i++) begin
            rdc(adrs[i], rsts[i]);
        end
        chk(synth_cfg.pump_cal_skip, 1'b0, "skip at reset");
    endtask : t_reset
    task automatic t_masks();
        for (int i = 0; i < 5; i++) begin
            wr(adrs[i], 8'hFF);
            rdc(adrs[i], msks[i]);
            wr(adrs[i], 8'h00);
            rdc(adrs[i], 8'h00);
        end
        chk(synth_cfg.pump_cal_skip, 1'b1, "skip with enable zero");
        rdc(scr_pkg::ADR_STATUS, 8'h01);
        wr(18'h00100, 8'h5A);
        rdc(18'h00100, 8'h00);
    endtask : t_masks
    // reload of stored results, as before a hop
    task automatic t_hop();
        wr(adrs[0], 8'h5B);
        wr(adrs[1], 8'h35);
        wr(adrs[2], 8'h2A);
        wr(adrs[3], 8'h3C);
        wr(adrs[4], 8'h81);
        repeat (2) @(posedge clk);
        chk({synth_cfg.pump_cfg, synth_cfg.pump_current_cal_enable, synth_cfg.pump_code}, 8'h5B, "pump");
        chk({synth_cfg.oscillator_core_high_select, synth_cfg.osc_current}, 6'h35, "osc");
        chk(synth_cfg.coarse_code, 6'h2A, "coarse");
        chk(synth_cfg.sens_test, 8'h81, "sens");
        chk(synth_cfg.cal_control, 7'h3C, "control");
        chk(synth_cfg.pump_cal_skip, 1'b0, "skip with enable one");
    endtask : t_hop
    task automatic t_wake(input logic use_b);
        deep_sleep_mode_a <= !use_b;
        deep_sleep_mode_b <= use_b;
        rdc(scr_pkg::ADR_STATUS, use_b ? 8'h04 : 8'h02);
        repeat (2) @(posedge clk);
        deep_sleep_mode_a <= 1'b0;
        deep_sleep_mode_b <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            rdc(adrs[i], rsts[i]);
        end
        rdc(adrs[3], 8'h3C);
    endtask : t_wake
    // mid-run reset brings back every register, also those that survive sleep
    task automatic t_rerst();
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            rdc(adrs[i], rsts[i]);
        end
    endtask : t_rerst
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        rst_b = 1'b0;
        av_req = '0;
        av_req.byteenable = 4'h1;
        deep_sleep_mode_a = 1'b0;
        deep_sleep_mode_b = 1'b0;
        fails = 0;
        n_tests = 0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_masks();
        t_hop();
        t_wake(1'b0);
        t_hop();
        t_wake(1'b1);
        t_rerst();
        print_verdict();
    end
endmodule : scr_synth_cal_regs_tb
